// [core/ims_pkg.sv]
package ims_pkg;

   localparam int NWORDS = 21;
   localparam int IDX_W = 5;

   // Word addresses on the serial register map
   localparam logic [15:0] A_INJ_DETECT = 16'h0BD2;
   localparam logic [15:0] A_LOC_TRIGGER = 16'h0BD3;
   localparam logic [15:0] A_LOC_COUNT = 16'h0BD4;
   localparam logic [15:0] A_SELFTEST_RELAY = 16'h0BD5;
   localparam logic [15:0] A_GROUND_RES_HI = 16'h0BD6;
   localparam logic [15:0] A_GROUND_RES_LO = 16'h0BD7;
   localparam logic [15:0] A_INH_ALARM_EN = 16'h0BD8;
   localparam logic [15:0] A_SAVER_EN = 16'h0BD9;
   localparam logic [15:0] A_SAVER_DELAY = 16'h0BDA;
   localparam logic [15:0] A_INH_INPUT_EN = 16'h0BDB;
   localparam logic [15:0] A_PRIM_DC_RES = 16'h0BDC;
   localparam logic [15:0] A_XFMR_COUNT = 16'h0BDD;
   localparam logic [15:0] A_ADAPT_OFS_HI = 16'h0BDE;
   localparam logic [15:0] A_ADAPT_OFS_LO = 16'h0BDF;
   localparam logic [15:0] A_PREV_LOGIC = 16'h0BE0;
   localparam logic [15:0] A_PREV_DELAY = 16'h0BE1;
   localparam logic [15:0] A_MAIN_MAP_HI = 16'h0BE4;
   localparam logic [15:0] A_MAIN_MAP_LO = 16'h0BE5;
   localparam logic [15:0] A_PREV_MAP_HI = 16'h0BE6;
   localparam logic [15:0] A_PREV_MAP_LO = 16'h0BE7;
   localparam logic [15:0] A_INH_SOURCE = 16'h0BE8;

   // Storage index of each word
   localparam logic [4:0] I_INJ_DETECT = 5'h00;
   localparam logic [4:0] I_LOC_TRIGGER = 5'h01;
   localparam logic [4:0] I_LOC_COUNT = 5'h02;
   localparam logic [4:0] I_SELFTEST_RELAY = 5'h03;
   localparam logic [4:0] I_GROUND_RES_HI = 5'h04;
   localparam logic [4:0] I_GROUND_RES_LO = 5'h05;
   localparam logic [4:0] I_INH_ALARM_EN = 5'h06;
   localparam logic [4:0] I_SAVER_EN = 5'h07;
   localparam logic [4:0] I_SAVER_DELAY = 5'h08;
   localparam logic [4:0] I_INH_INPUT_EN = 5'h09;
   localparam logic [4:0] I_PRIM_DC_RES = 5'h0A;
   localparam logic [4:0] I_XFMR_COUNT = 5'h0B;
   localparam logic [4:0] I_ADAPT_OFS_HI = 5'h0C;
   localparam logic [4:0] I_ADAPT_OFS_LO = 5'h0D;
   localparam logic [4:0] I_PREV_LOGIC = 5'h0E;
   localparam logic [4:0] I_PREV_DELAY = 5'h0F;
   localparam logic [4:0] I_MAIN_MAP_HI = 5'h10;
   localparam logic [4:0] I_MAIN_MAP_LO = 5'h11;
   localparam logic [4:0] I_PREV_MAP_HI = 5'h12;
   localparam logic [4:0] I_PREV_MAP_LO = 5'h13;
   localparam logic [4:0] I_INH_SOURCE = 5'h14;

   // Power-up values, word 20 first
   localparam logic [NWORDS-1:0][15:0] RESET_VAL = {
      16'h0000, 16'h0001, 16'h0000, 16'h0010, 16'h0000,
      16'h0000, 16'h0002, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h012C, 16'h0000, 16'h0001,
      16'hFFFF, 16'hFFFF, 16'h0001, 16'h0000, 16'h0000,
      16'h0000};

   // Writable bits, word 20 first; event maps keep only their event bits
   localparam logic [NWORDS-1:0][15:0] WRITE_MASK = {
      16'hFFFF, 16'h0110, 16'h0101, 16'h0101, 16'h0101,
      16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
      16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
      16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
      16'hFFFF};

   // Value limits
   localparam logic [15:0] LOC_COUNT_MAX = 16'h0032;
   localparam logic [15:0] LOC_TRIGGER_MAX = 16'h0003;
   localparam logic [15:0] SAVER_DELAY_MIN = 16'h001E;
   localparam logic [15:0] SAVER_DELAY_MAX = 16'h0E10;
   localparam logic [15:0] PRIM_DC_RES_MAX = 16'h0032;
   localparam logic [15:0] PREV_DELAY_MAX = 16'h1C20;
   localparam logic [15:0] PREV_LOGIC_MIN = 16'h0001;
   localparam logic [15:0] PREV_LOGIC_MAX = 16'h0003;
   localparam logic [15:0] XFMR_ONE = 16'h0001;
   localparam logic [15:0] XFMR_THREE = 16'h0003;
   localparam logic [15:0] FLAG_MAX = 16'h0001;

   // Answer codes
   localparam logic [1:0] ANS_OK = 2'h0;
   localparam logic [1:0] ANS_BAD_ADDR = 2'h2;
   localparam logic [1:0] ANS_BAD_VALUE = 2'h3;

   typedef enum logic [1:0] {
      TRIG_OFF,
      TRIG_MAIN_ALARM,
      TRIG_PREV_ALARM,
      TRIG_LOCATOR
   } ims_trigger_t;

   typedef struct packed {
      logic req;
      logic write;
      logic [15:0] addr;
      logic [15:0] wdata;
   } ims_req_t;

   typedef struct packed {
      logic ack;
      logic [1:0] code;
      logic [15:0] rdata;
   } ims_ans_t;

   typedef struct packed {
      logic inj_detect_en;
      ims_trigger_t fault_locator_trigger;
      logic [5:0] fault_locator_count;
      logic selftest_relay_use;
      logic [31:0] grounding_resistance_setting;
      logic inhibit_alarm_en;
      logic saver_en;
      logic [15:0] saver_delay_s;
      logic inhibit_input_en;
      logic [15:0] prim_dc_res;
      logic [1:0] xfmr_count;
      logic [31:0] adapter_offset;
      logic [1:0] prev_relay_logic;
      logic [15:0] prev_delay_s;
      logic [31:0] main_relay_map;
      logic [31:0] prev_relay_map;
      logic inhibit_external;
   } ims_settings_t;

endpackage

// [core/ims_word_reg.sv]
`timescale 1ns/1ps
`default_nettype none
module ims_word_reg #(
   parameter logic [15:0] RESET = 16'h0000,
   parameter logic [15:0] MASK = 16'hFFFF
) (
   input wire logic clk, // System clock
   input wire logic rst, // Async reset, high
   input wire logic we, // Accepted write
   input wire logic [15:0] wdata, // Written word
   output logic [15:0] q // Stored word
);
   logic [15:0] q_reg;
   logic [15:0] q_next;

   // Bits outside the mask keep their power-up value
   assign q_next = (wdata & MASK) | (RESET & ~MASK);
   assign q = q_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q_reg <= RESET;
      end else if (we) begin
         q_reg <= q_next;
      end
   end
endmodule // ims_word_reg
`default_nettype wire

// [core/ims_range_check.sv]
`timescale 1ns/1ps
`default_nettype none
module ims_range_check (
   input wire logic [4:0] idx, // Word index
   input wire logic [15:0] value, // Proposed value
   output logic ok // Value acceptable
);
   always_comb begin
      unique case (idx)
         ims_pkg::I_INJ_DETECT,
         ims_pkg::I_SELFTEST_RELAY,
         ims_pkg::I_INH_ALARM_EN,
         ims_pkg::I_SAVER_EN,
         ims_pkg::I_INH_INPUT_EN,
         ims_pkg::I_INH_SOURCE:
            ok = value <= ims_pkg::FLAG_MAX;
         ims_pkg::I_LOC_TRIGGER:
            ok = value <= ims_pkg::LOC_TRIGGER_MAX;
         ims_pkg::I_LOC_COUNT:
            ok = value <= ims_pkg::LOC_COUNT_MAX;
         ims_pkg::I_SAVER_DELAY:
            ok = value >= ims_pkg::SAVER_DELAY_MIN
               && value <= ims_pkg::SAVER_DELAY_MAX;
         ims_pkg::I_PRIM_DC_RES:
            ok = value <= ims_pkg::PRIM_DC_RES_MAX;
         ims_pkg::I_XFMR_COUNT:
            ok = value == 16'h0000 || value == ims_pkg::XFMR_ONE
               || value == ims_pkg::XFMR_THREE;
         ims_pkg::I_PREV_LOGIC:
            ok = value >= ims_pkg::PREV_LOGIC_MIN
               && value <= ims_pkg::PREV_LOGIC_MAX;
         ims_pkg::I_PREV_DELAY:
            ok = value <= ims_pkg::PREV_DELAY_MAX;
         default:
            ok = 1'b1;
      endcase
   end
endmodule // ims_range_check
`default_nettype wire

// [core/ims_settings_bank.sv]
// Behaviour
// - Disconnect detection word, 0 off, 1 on
// - Locator trigger codes 0..3, default off
// - Locator count 0 to 50, reset zero
// - Self-test relay use word, reset one
// - Grounding resistance 32-bit, all-ones off default
// - Alarm during inhibition word, reset one
// - Screen saver delay seconds, reset 300
// - Inhibition source internal 0, external 1
// - Transformer count only 0, 1, 3
// - Preventive relay logic, reset failsafe 2
// - Preventive alarm delay seconds, reset 0
// - Main map event bits 0,8,16,24
// - Main map bit 4 fixed, read-only
// - Preventive map bit 0 fixed, bit 4 writable
`timescale 1ns/1ps
`default_nettype none
module ims_settings_bank (
   input wire logic clk, // System clock, 100 MHz
   input wire logic rst, // Async reset, high
   input wire ims_pkg::ims_req_t bus_req, // Word request from protocol
   output ims_pkg::ims_ans_t bus_ans, // Answer, one cycle later
   output ims_pkg::ims_settings_t settings // Current settings
);
   localparam int N = ims_pkg::NWORDS;

   // Address to storage index; valid flag in bit 5
   function automatic logic [5:0] addr_to_index(input logic [15:0] a);
      logic [5:0] r;
      r = 6'h00;
      unique case (a)
         ims_pkg::A_INJ_DETECT: r = {1'b1, ims_pkg::I_INJ_DETECT};
         ims_pkg::A_LOC_TRIGGER: r = {1'b1, ims_pkg::I_LOC_TRIGGER};
         ims_pkg::A_LOC_COUNT: r = {1'b1, ims_pkg::I_LOC_COUNT};
         ims_pkg::A_SELFTEST_RELAY: r = {1'b1, ims_pkg::I_SELFTEST_RELAY};
         ims_pkg::A_GROUND_RES_HI: r = {1'b1, ims_pkg::I_GROUND_RES_HI};
         ims_pkg::A_GROUND_RES_LO: r = {1'b1, ims_pkg::I_GROUND_RES_LO};
         ims_pkg::A_INH_ALARM_EN: r = {1'b1, ims_pkg::I_INH_ALARM_EN};
         ims_pkg::A_SAVER_EN: r = {1'b1, ims_pkg::I_SAVER_EN};
         ims_pkg::A_SAVER_DELAY: r = {1'b1, ims_pkg::I_SAVER_DELAY};
         ims_pkg::A_INH_INPUT_EN: r = {1'b1, ims_pkg::I_INH_INPUT_EN};
         ims_pkg::A_PRIM_DC_RES: r = {1'b1, ims_pkg::I_PRIM_DC_RES};
         ims_pkg::A_XFMR_COUNT: r = {1'b1, ims_pkg::I_XFMR_COUNT};
         ims_pkg::A_ADAPT_OFS_HI: r = {1'b1, ims_pkg::I_ADAPT_OFS_HI};
         ims_pkg::A_ADAPT_OFS_LO: r = {1'b1, ims_pkg::I_ADAPT_OFS_LO};
         ims_pkg::A_PREV_LOGIC: r = {1'b1, ims_pkg::I_PREV_LOGIC};
         ims_pkg::A_PREV_DELAY: r = {1'b1, ims_pkg::I_PREV_DELAY};
         ims_pkg::A_MAIN_MAP_HI: r = {1'b1, ims_pkg::I_MAIN_MAP_HI};
         ims_pkg::A_MAIN_MAP_LO: r = {1'b1, ims_pkg::I_MAIN_MAP_LO};
         ims_pkg::A_PREV_MAP_HI: r = {1'b1, ims_pkg::I_PREV_MAP_HI};
         ims_pkg::A_PREV_MAP_LO: r = {1'b1, ims_pkg::I_PREV_MAP_LO};
         ims_pkg::A_INH_SOURCE: r = {1'b1, ims_pkg::I_INH_SOURCE};
         default: r = 6'h00;
      endcase
      return r;
   endfunction

   logic [N-1:0][15:0] word;
   logic [N-1:0] word_we;
   logic [5:0] dec;
   logic addr_hit;
   logic [4:0] idx;
   logic value_ok;
   logic wr_accept;
   logic [15:0] rd_word;
   logic [1:0] code_next;
   logic ack_reg;
   logic [1:0] code_reg;
   logic [15:0] rdata_reg;

   // Request decode
   assign dec = addr_to_index(bus_req.addr);
   assign addr_hit = dec[5];
   assign idx = dec[4:0];

   ims_range_check u_range (
      .idx(idx),
      .value(bus_req.wdata),
      .ok(value_ok)
   );

   // Only in-range values reach storage
   assign wr_accept = bus_req.req && bus_req.write && addr_hit && value_ok;

   // One register per word; masks fix read-only and reserved bits
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_word
         assign word_we[g] = wr_accept && (idx == 5'(g));
         ims_word_reg #(
            .RESET(ims_pkg::RESET_VAL[g]),
            .MASK(ims_pkg::WRITE_MASK[g])
         ) u_word (
            .clk(clk),
            .rst(rst),
            .we(word_we[g]),
            .wdata(bus_req.wdata),
            .q(word[g])
         );
      end
   endgenerate

   assign rd_word = addr_hit ? word[idx] : 16'h0000;

   assign code_next = !addr_hit ? ims_pkg::ANS_BAD_ADDR :
      (bus_req.write && !value_ok) ? ims_pkg::ANS_BAD_VALUE :
      ims_pkg::ANS_OK;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_reg <= 1'b0;
         code_reg <= ims_pkg::ANS_OK;
         rdata_reg <= 16'h0000;
      end else begin
         ack_reg <= bus_req.req;
         if (bus_req.req) begin
            code_reg <= code_next;
            rdata_reg <= bus_req.write ? 16'h0000 : rd_word;
         end
      end
   end

   assign bus_ans.ack = ack_reg;
   assign bus_ans.code = code_reg;
   assign bus_ans.rdata = rdata_reg;

   // Settings as seen by the monitoring logic
   assign settings.inj_detect_en = word[ims_pkg::I_INJ_DETECT][0];
   assign settings.fault_locator_trigger =
      ims_pkg::ims_trigger_t'(word[ims_pkg::I_LOC_TRIGGER][1:0]);
   assign settings.fault_locator_count =
      word[ims_pkg::I_LOC_COUNT][5:0];
   assign settings.selftest_relay_use =
      word[ims_pkg::I_SELFTEST_RELAY][0];
   assign settings.grounding_resistance_setting =
      {word[ims_pkg::I_GROUND_RES_HI], word[ims_pkg::I_GROUND_RES_LO]};
   assign settings.inhibit_alarm_en =
      word[ims_pkg::I_INH_ALARM_EN][0];
   assign settings.saver_en = word[ims_pkg::I_SAVER_EN][0];
   assign settings.saver_delay_s = word[ims_pkg::I_SAVER_DELAY];
   assign settings.inhibit_input_en = word[ims_pkg::I_INH_INPUT_EN][0];
   assign settings.prim_dc_res = word[ims_pkg::I_PRIM_DC_RES];
   assign settings.xfmr_count = word[ims_pkg::I_XFMR_COUNT][1:0];
   assign settings.adapter_offset =
      {word[ims_pkg::I_ADAPT_OFS_HI], word[ims_pkg::I_ADAPT_OFS_LO]};
   assign settings.prev_relay_logic =
      word[ims_pkg::I_PREV_LOGIC][1:0];
   assign settings.prev_delay_s = word[ims_pkg::I_PREV_DELAY];
   assign settings.main_relay_map =
      {word[ims_pkg::I_MAIN_MAP_HI], word[ims_pkg::I_MAIN_MAP_LO]};
   assign settings.prev_relay_map =
      {word[ims_pkg::I_PREV_MAP_HI], word[ims_pkg::I_PREV_MAP_LO]};
   assign settings.inhibit_external =
      word[ims_pkg::I_INH_SOURCE][0];
endmodule // ims_settings_bank
`default_nettype wire

// [bench/ims_bus_master.sv]
`timescale 1ns/1ps
`default_nettype none
module ims_bus_master (
   input wire logic clk, // System clock
   output ims_pkg::ims_req_t bus_req, // Request to the bank
   input wire ims_pkg::ims_ans_t bus_ans // Answer from the bank
);
   initial bus_req = '0;
   // One strobe per word; answer taken while ack stands, then lines inverted
   task automatic xfer(input logic wr, input logic [15:0] a, d,
                       output logic ack, output logic [1:0] code,
                       output logic [15:0] rd);
      @(negedge clk);
      bus_req = '{req: 1'b1, write: wr, addr: a, wdata: d};
      @(negedge clk);
      ack = bus_ans.ack;
      code = bus_ans.code;
      rd = bus_ans.rdata;
      bus_req = '{req: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
   endtask
endmodule // ims_bus_master
`default_nettype wire

// [bench/ims_settings_bank_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module ims_settings_bank_monitor (
   input wire logic clk, // System clock
   input wire logic rst, // Async reset, high
   input wire ims_pkg::ims_req_t bus_req, // Word request
   input wire ims_pkg::ims_ans_t bus_ans, // Answer
   input wire ims_pkg::ims_settings_t settings // Decoded settings
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire logic wr = bus_req.req && bus_req.write;
   a_ack_one_cycle: assert property (bus_ans.ack == $past(bus_req.req))
      else $error("answer strobe not one cycle after request");
   a_bad_count_kept: assert property (wr &&
      bus_req.addr == ims_pkg::A_LOC_COUNT && bus_req.wdata > 16'h0032
      |=> bus_ans.code == ims_pkg::ANS_BAD_VALUE
      && $stable(settings.fault_locator_count))
      else $error("out of range count not refused");
   a_count_stored: assert property (wr &&
      bus_req.addr == ims_pkg::A_LOC_COUNT && bus_req.wdata <= 16'h0032
      |=> settings.fault_locator_count == $past(bus_req.wdata[5:0]))
      else $error("locator count not stored");
   a_trigger_stored: assert property (wr &&
      bus_req.addr == ims_pkg::A_LOC_TRIGGER && bus_req.wdata <= 16'h0003
      |=> settings.fault_locator_trigger == $past(bus_req.wdata[1:0]))
      else $error("trigger code not stored");
   a_ground_high: assert property (wr &&
      bus_req.addr == ims_pkg::A_GROUND_RES_HI
      |=> settings.grounding_resistance_setting[31:16] == $past(bus_req.wdata))
      else $error("grounding high word not stored");
   a_map_fixed_bits: assert property (settings.main_relay_map[4] &&
      settings.prev_relay_map[0])
      else $error("fixed alarm bit cleared");
   a_reserved_zero: assert property (
      (settings.main_relay_map & 32'hFEFEFEEE) == 32'h00000000 &&
      (settings.prev_relay_map & 32'hFEFEFEEE) == 32'h00000000)
      else $error("reserved map bit set");
   a_xfmr_legal: assert property (settings.xfmr_count != 2'h2)
      else $error("illegal transformer count");
   a_saver_range: assert property (settings.saver_delay_s >= 16'h001E &&
      settings.saver_delay_s <= 16'h0E10)
      else $error("saver delay out of range");
   a_logic_legal: assert property (settings.prev_relay_logic != 2'h0)
      else $error("illegal relay logic code");
endmodule // ims_settings_bank_monitor
bind ims_settings_bank ims_settings_bank_monitor u_monitor (.clk(clk),
   .rst(rst), .bus_req(bus_req), .bus_ans(bus_ans), .settings(settings));
`default_nettype wire

// [bench/test_ims_settings_bank.sv]
`timescale 1ns/1ps
`default_nettype none
module test_ims_settings_bank;
   logic clk;
   logic rst;
   ims_pkg::ims_req_t bus_req;
   ims_pkg::ims_ans_t bus_ans;
   ims_pkg::ims_settings_t settings;
   int fails = 0;
   int comparisons = 0;
   logic ack;
   logic [1:0] code;
   logic [15:0] rd;
   ims_settings_bank DUT (.clk(clk), .rst(rst), .bus_req(bus_req),
      .bus_ans(bus_ans), .settings(settings));
   ims_bus_master u_master (.clk(clk), .bus_req(bus_req), .bus_ans(bus_ans));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rw(input logic wr, input logic [15:0] a, d);
      u_master.xfer(wr, a, d, ack, code, rd);
      check(32'(ack), 32'h00000001);
   endtask
   task automatic test_power_up();
      logic [15:0] e [21] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001,
         16'hFFFF, 16'hFFFF, 16'h0001, 16'h0000, 16'h012C, 16'h0000, 16'h0000,
         16'h0000, 16'h0000, 16'h0000, 16'h0002, 16'h0000, 16'h0000, 16'h0010,
         16'h0000, 16'h0001, 16'h0000};
      for (int i = 0; i < 21; i++) begin
         rw(1'b0, (i < 16) ? 16'(16'h0BD2 + i) : 16'(16'h0BD4 + i), 16'h0000);
         check(32'(rd), 32'(e[i]));
      end
      check(settings.grounding_resistance_setting, 32'hFFFFFFFF);
      check(32'(settings.saver_delay_s), 32'h0000012C);
      check(32'(settings.prev_relay_logic), 32'h00000002);
   endtask
   task automatic test_ranges();
      logic [15:0] t [13][3] = '{
         '{16'h0BD2, 16'h0001, 16'h0002}, '{16'h0BD3, 16'h0003, 16'h0004},
         '{16'h0BD4, 16'h0032, 16'h0033}, '{16'h0BD5, 16'h0000, 16'h0002},
         '{16'h0BD8, 16'h0000, 16'h0002}, '{16'h0BDA, 16'h0E10, 16'h0E11},
         '{16'h0BDA, 16'h001E, 16'h001D}, '{16'h0BDD, 16'h0003, 16'h0002},
         '{16'h0BE0, 16'h0003, 16'h0000}, '{16'h0BE1, 16'h1C20, 16'h1C21},
         '{16'h0BE8, 16'h0001, 16'h0002}, '{16'h0BDB, 16'h0001, 16'h0002},
         '{16'h0BDC, 16'h0032, 16'h0033}};
      for (int i = 0; i < 13; i++) begin
         rw(1'b1, t[i][0], t[i][1]);
         check(32'(code), 32'(ims_pkg::ANS_OK));
         rw(1'b1, t[i][0], t[i][2]);
         check(32'(code), 32'(ims_pkg::ANS_BAD_VALUE));
         rw(1'b0, t[i][0], 16'h0000);
         check(32'(rd), 32'(t[i][1]));
      end
      check(32'(settings.fault_locator_count), 32'h00000032);
      check(32'(settings.saver_delay_s), 32'h0000001E);
      check(32'(settings.prev_delay_s), 32'h00001C20);
      check(32'(settings.xfmr_count), 32'h00000003);
      check(32'(settings.prev_relay_logic), 32'h00000003);
      check(32'(settings.inj_detect_en), 32'h00000001);
      check(32'(settings.selftest_relay_use), 32'h00000000);
      check(32'(settings.inhibit_alarm_en), 32'h00000000);
      check(32'(settings.inhibit_external), 32'h00000001);
      check(32'(settings.inhibit_input_en), 32'h00000001);
      check(32'(settings.prim_dc_res), 32'h00000032);
      for (int c = 0; c < 4; c++) begin
         rw(1'b1, 16'h0BD3, 16'(c));
         check(32'(settings.fault_locator_trigger), 32'(c));
      end
   endtask
   task automatic test_maps();
      rw(1'b1, 16'h0BE4, 16'hFFFF);
      rw(1'b1, 16'h0BE5, 16'hFFFF);
      rw(1'b0, 16'h0BE4, 16'h0000);
      check(32'(rd), 32'h00000101);
      rw(1'b0, 16'h0BE5, 16'h0000);
      check(32'(rd), 32'h00000111);
      rw(1'b1, 16'h0BE5, 16'h0000);
      check(settings.main_relay_map, 32'h01010010);
      rw(1'b1, 16'h0BE6, 16'hFFFF);
      rw(1'b1, 16'h0BE7, 16'hFFFF);
      check(settings.prev_relay_map, 32'h01010111);
      rw(1'b1, 16'h0BE7, 16'h0000);
      rw(1'b0, 16'h0BE7, 16'h0000);
      check(32'(rd), 32'h00000001);
      rw(1'b1, 16'h0BD6, 16'h1234);
      rw(1'b1, 16'h0BD7, 16'h5678);
      check(settings.grounding_resistance_setting, 32'h12345678);
      rw(1'b1, 16'h0BDE, 16'hABCD);
      rw(1'b1, 16'h0BDF, 16'h0123);
      check(settings.adapter_offset, 32'hABCD0123);
      rw(1'b1, 16'h0BD9, 16'h0001);
      check(32'(settings.saver_en), 32'h00000001);
   endtask
   task automatic test_bad_addr();
      logic [15:0] a [4] = '{16'h0BE2, 16'h0BE3, 16'h0BD1, 16'h0BE9};
      for (int i = 0; i < 4; i++) begin
         rw(i[0], a[i], 16'h1234);
         check({14'h0000, code, rd}, 32'h00020000);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      #20000;
      fails++;
      report_and_stop();
   end
   initial begin
      rst = 1'b1;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      test_power_up();
      test_ranges();
      test_maps();
      test_bad_addr();
      report_and_stop();
   end
endmodule // test_ims_settings_bank
`default_nettype wire
